//--- hw/dir_pkg.sv
// Constants and types for the paged instruction memory window
package dir_pkg;
   // Register offsets within every page
   localparam logic [6:0] REG_PAGE_SELECT = 7'h00;
   localparam logic [6:0] REG_RESERVED_ONE = 7'h01;
   localparam logic [6:0] REG_INSTR_FIRST = 7'h02;
   localparam logic [6:0] REG_INSTR_LAST = 7'h61;
   localparam logic [6:0] REG_RESERVED_TAIL = 7'h62;
   // Page ranges of the two engines
   localparam logic [7:0] PAGE_REC_FIRST = 8'h20;
   localparam logic [7:0] PAGE_REC_LAST = 8'h2B;
   localparam logic [7:0] PAGE_PLAY_FIRST = 8'h40;
   localparam logic [7:0] PAGE_PLAY_LAST = 8'h5F;
   // Values after reset
   localparam logic [7:0] PAGE_RESET = 8'h00;
   localparam logic [7:0] RESERVED_RESET = 8'h00;
   // Memory shapes
   localparam int REC_WIDTH = 20;
   localparam int PLAY_WIDTH = 24;
   localparam int REC_DEPTH = 384;
   localparam int PLAY_DEPTH = 1024;
   localparam int REC_AW = 9;
   localparam int PLAY_AW = 10;
   localparam int REG_AW = 7;
   localparam int TRIPLET_COUNT = 32;

   typedef enum logic [1:0] {ENG_NONE, ENG_REC, ENG_PLAY} dir_engine_t;
   typedef enum logic [1:0] {LANE_HIGH, LANE_MID, LANE_LOW} dir_lane_t;

   // Instruction number within a page for a register 2..97
   function automatic logic [4:0] dir_triplet(input logic [6:0] reg_addr);
      logic [6:0] ofs;
      ofs = reg_addr - REG_INSTR_FIRST;
      dir_triplet = 5'(ofs / 7'd3);
   endfunction : dir_triplet

   // Byte lane of a register 2..97 inside its instruction
   function automatic dir_lane_t dir_lane(input logic [6:0] reg_addr);
      logic [6:0] ofs;
      ofs = reg_addr - REG_INSTR_FIRST;
      case (ofs % 7'd3)
         7'd0: dir_lane = LANE_HIGH;
         7'd1: dir_lane = LANE_MID;
         default: dir_lane = LANE_LOW;
      endcase
   endfunction : dir_lane
endpackage : dir_pkg

//--- hw/dir_map_if.sv
// Carrier between the window and its address decoder
`timescale 1ns/10ps
interface dir_map_if;
   import dir_pkg::*;
   logic [7:0] page;
   logic [6:0] reg_addr;
   dir_engine_t engine;
   dir_lane_t lane;
   logic [9:0] word_idx;

   modport decoder (input page, input reg_addr, output engine, output lane, output word_idx);
   modport user (output page, output reg_addr, input engine, input lane, input word_idx);
endinterface : dir_map_if

//--- hw/dir_addr_map.sv
// Page and register to engine, word and byte lane decoder
`timescale 1ns/10ps
module dir_addr_map
   import dir_pkg::*;
(
   // Decode carrier
   dir_map_if.decoder m
);
   logic in_instr;
   logic [7:0] page_ofs;

   // Only registers 2..97 map onto instruction bytes; the tail stays unmapped
   assign in_instr = (m.reg_addr >= REG_INSTR_FIRST) && (m.reg_addr <= REG_INSTR_LAST);

   // Engine choice by page range
   always_comb begin
      m.engine = ENG_NONE;
      page_ofs = 8'h00;
      if (in_instr && m.page >= PAGE_REC_FIRST && m.page <= PAGE_REC_LAST) begin
         m.engine = ENG_REC;
         page_ofs = m.page - PAGE_REC_FIRST;
      end else if (in_instr && m.page >= PAGE_PLAY_FIRST && m.page <= PAGE_PLAY_LAST) begin
         m.engine = ENG_PLAY;
         page_ofs = m.page - PAGE_PLAY_FIRST;
      end
   end

   // Word is 32 per page plus the triplet number
   assign m.word_idx = {page_ofs[4:0], dir_triplet(m.reg_addr)};
   assign m.lane = dir_lane(m.reg_addr);
endmodule : dir_addr_map

//--- hw/dir_instr_window.sv
// Paged register window onto the record and playback instruction memories
//
// How it works
// - Register 0 of every page is a read/write page selector, zero after reset, choosing page n.
// - On record pages register 2 holds instruction bits 19:16 low, upper nibble reserved.
// - On record pages registers 3 and 4 hold bits 15:8 and 7:0 of the instruction.
// - Record registers 5..97 form triplets holding instructions 1..31 in order.
// - Registers 98..127 of record pages are reserved and the host writes only defaults.
// - Pages 33..43 repeat page 32, each holding the next 32 record instructions.
// - On playback pages register 2 holds instruction bits 23:16 in all eight bits.
// - On playback pages registers 3 and 4 hold bits 15:8 and 7:0 of the instruction.
// - Playback registers 5..97 form triplets holding instructions 1..31 in order.
// - Pages 65..95 repeat page 64, ending with instructions 992..1023 on page 95.
//
// Register map seen by the host on every page
//    0        page selector, global, survives any page change
//    1        reserved byte, kept as plain storage so a default write reads back
//    2..97    instruction triplets, high byte first, then middle, then low
//    98..127  reserved tail, not stored, reads zero, writes dropped
//
// Page ranges
//    32..43   record engine, 12 pages of 32 words, 384 words of 20 bits
//    64..95   playback engine, 32 pages of 32 words, 1024 words of 24 bits
//    others   instruction registers read zero and ignore writes
//
// Timing of the register port
//    A strobe is taken on the rising edge at which it stands high.
//    A read answers one cycle later with a one-cycle valid pulse; the byte
//    itself stays on the read data until the next read replaces it.
//    A write has no answer and lands at the same edge.
//    Back to back strobes are allowed on every cycle.
//
// Hazards and limits
//    The decoder uses the page already in force, so a page write and an
//    instruction access in one cycle still address the old page.
//    A read and a write of the same byte in one cycle return the old byte.
//    The instruction memories have no reset; an engine fetching a word that
//    was never loaded gets an undefined value, so hosts must load first.
//    Fetch addresses beyond the memory depth are not allowed.
//    The upper nibble of the record high byte is not stored, trading the
//    reserved bits for four fewer flops per record word.
//
// Engine fetch ports
//    Each engine reads its own memory through a registered port with one
//    cycle of latency, independent of the host window.
//    A host write and an engine fetch of one word in the same cycle give the
//    engine the old word; the new word is seen on the following fetch.
//
// Reset
//    Synchronous, active high; the selector, the reserved byte, the read
//    answer and both fetch registers clear, the memories keep their content.
`timescale 1ns/10ps
module dir_instr_window
   import dir_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Control port register access
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [6:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   // Current page
   output logic [7:0] page_sel,
   // Record engine fetch port
   input wire logic [8:0] rec_fetch_addr,
   output logic [19:0] rec_fetch_data,
   // Playback engine fetch port
   input wire logic [9:0] play_fetch_addr,
   output logic [23:0] play_fetch_data
);
   logic [7:0] page_reg;
   logic [7:0] rsvd_one_reg;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic rvalid_reg;
   logic [REC_WIDTH-1:0] rec_mem [REC_DEPTH];
   logic [PLAY_WIDTH-1:0] play_mem [PLAY_DEPTH];
   logic [REC_WIDTH-1:0] rec_fetch_reg;
   logic [PLAY_WIDTH-1:0] play_fetch_reg;
   logic [REC_WIDTH-1:0] rec_word;
   logic [PLAY_WIDTH-1:0] play_word;
   logic [REC_AW-1:0] rec_idx;
   logic [PLAY_AW-1:0] play_idx;

   dir_map_if map ();

   // Decoder sees the page already in force, so a page write affects later accesses
   assign map.page = page_reg;
   assign map.reg_addr = reg_addr;

   dir_addr_map u_map (
      .m (map)
   );

   assign rec_idx = map.word_idx[REC_AW-1:0];
   assign play_idx = map.word_idx;
   assign rec_word = rec_mem[rec_idx];
   assign play_word = play_mem[play_idx];

   // Page selector, shared by every page at register 0
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         page_reg <= PAGE_RESET;
      end else if (reg_wr_en && reg_addr == REG_PAGE_SELECT) begin
         page_reg <= reg_wdata;
      end
   end

   // Register 1 is kept as plain storage; hosts are expected to write only its default
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rsvd_one_reg <= RESERVED_RESET;
      end else if (reg_wr_en && reg_addr == REG_RESERVED_ONE) begin
         rsvd_one_reg <= reg_wdata;
      end
   end

   // Record memory byte writes; no reset, contents are undefined until loaded
   always_ff @(posedge sys_clk) begin
      if (reg_wr_en && map.engine == ENG_REC) begin
         case (map.lane)
            LANE_HIGH: begin
               rec_mem[rec_idx][19:16] <= reg_wdata[3:0];
            end
            LANE_MID: begin
               rec_mem[rec_idx][15:8] <= reg_wdata;
            end
            LANE_LOW: begin
               rec_mem[rec_idx][7:0] <= reg_wdata;
            end
            default: begin
            end
         endcase
      end
   end

   // Playback memory byte writes
   always_ff @(posedge sys_clk) begin
      if (reg_wr_en && map.engine == ENG_PLAY) begin
         case (map.lane)
            LANE_HIGH: begin
               play_mem[play_idx][23:16] <= reg_wdata;
            end
            LANE_MID: begin
               play_mem[play_idx][15:8] <= reg_wdata;
            end
            LANE_LOW: begin
               play_mem[play_idx][7:0] <= reg_wdata;
            end
            default: begin
            end
         endcase
      end
   end

   // Read data select; reserved tail and instruction bytes of unused pages read zero
   always_comb begin
      rdata_next = 8'h00;
      if (reg_addr == REG_PAGE_SELECT) begin
         rdata_next = page_reg;
      end else if (reg_addr == REG_RESERVED_ONE) begin
         rdata_next = rsvd_one_reg;
      end else if (map.engine == ENG_REC) begin
         case (map.lane)
            LANE_HIGH: rdata_next = {4'h0, rec_word[19:16]};
            LANE_MID: rdata_next = rec_word[15:8];
            default: rdata_next = rec_word[7:0];
         endcase
      end else if (map.engine == ENG_PLAY) begin
         case (map.lane)
            LANE_HIGH: rdata_next = play_word[23:16];
            LANE_MID: rdata_next = play_word[15:8];
            default: rdata_next = play_word[7:0];
         endcase
      end
   end

   // Read answer one cycle after the request
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rdata_reg <= 8'h00;
         rvalid_reg <= 1'b0;
      end else begin
         rvalid_reg <= reg_rd_en;
         if (reg_rd_en) begin
            rdata_reg <= rdata_next;
         end
      end
   end

   // Engine fetch ports, registered; a write and fetch to one word shows the old word
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rec_fetch_reg <= '0;
         play_fetch_reg <= '0;
      end else begin
         rec_fetch_reg <= rec_mem[rec_fetch_addr];
         play_fetch_reg <= play_mem[play_fetch_addr];
      end
   end

   assign reg_rdata = rdata_reg;
   assign reg_rvalid = rvalid_reg;
   assign page_sel = page_reg;
   assign rec_fetch_data = rec_fetch_reg;
   assign play_fetch_data = play_fetch_reg;
endmodule : dir_instr_window

//--- dv/dir_window_sva.sv
// Checker for the register port of the instruction window
`timescale 1ns/10ps
module dir_window_sva
   import dir_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Register port
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [6:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire logic [7:0] page_sel
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Address classes; instruction bytes outside both engine page ranges read as zero
   wire instr_reg = reg_addr >= REG_INSTR_FIRST && reg_addr <= REG_INSTR_LAST;
   wire rec_pg = page_sel >= PAGE_REC_FIRST && page_sel <= PAGE_REC_LAST;
   wire play_pg = page_sel >= PAGE_PLAY_FIRST && page_sel <= PAGE_PLAY_LAST;
   wire hi_lane = ((reg_addr - REG_INSTR_FIRST) % 7'h03) == 7'h00;
   wire pg_wr = reg_wr_en && reg_addr == REG_PAGE_SELECT;
   property p_pg_wr; pg_wr |=> page_sel == $past(reg_wdata); endproperty
   a_pg_wr: assert property (p_pg_wr) else $error("page write lost");
   property p_pg_keep; !pg_wr |=> $stable(page_sel); endproperty
   a_pg_keep: assert property (p_pg_keep) else $error("page moved");
   property p_ans; reg_rd_en |=> reg_rvalid; endproperty
   a_ans: assert property (p_ans) else $error("no read answer");
   property p_quiet; !reg_rd_en |=> !reg_rvalid; endproperty
   a_quiet: assert property (p_quiet) else $error("stray answer");
   property p_pg_rd; reg_rd_en && !pg_wr && reg_addr == 7'h00 |=> reg_rdata == page_sel; endproperty
   a_pg_rd: assert property (p_pg_rd) else $error("page readback");
   property p_tail; reg_rd_en && reg_addr >= REG_RESERVED_TAIL |=> reg_rdata == 8'h00; endproperty
   a_tail: assert property (p_tail) else $error("tail not zero");
   property p_nib; reg_rd_en && instr_reg && hi_lane && rec_pg |=> reg_rdata[7:4] == 4'h0; endproperty
   a_nib: assert property (p_nib) else $error("upper nibble set");
   property p_off; reg_rd_en && instr_reg && !rec_pg && !play_pg |=> reg_rdata == 8'h00; endproperty
   a_off: assert property (p_off) else $error("off page byte");
endmodule : dir_window_sva
bind dir_instr_window dir_window_sva u_sva (.*);

//--- dv/test_dsp_instruction_ram_window.sv
// Self-checking bench for the paged instruction window
`timescale 1ns/10ps
module test_dsp_instruction_ram_window;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic reg_wr_en = 1'b0;
   logic reg_rd_en = 1'b0;
   logic [6:0] reg_addr = 7'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata, page_sel;
   logic reg_rvalid;
   logic [8:0] rec_fetch_addr = 9'h000;
   logic [9:0] play_fetch_addr = 10'h000;
   logic [19:0] rec_fetch_data;
   logic [23:0] play_fetch_data;
   int err_total = 0;
   int comparisons = 0;
   int cycles = 0;
   // 100 MHz clock
   always #5 sys_clk = ~sys_clk;
   dir_instr_window DUT (.sys_clk(sys_clk), .rst(rst), .reg_wr_en(reg_wr_en),
      .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .page_sel(page_sel),
      .rec_fetch_addr(rec_fetch_addr), .rec_fetch_data(rec_fetch_data),
      .play_fetch_addr(play_fetch_addr), .play_fetch_data(play_fetch_data));
   // Hang guard; the run needs about 120 cycles
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         err_total++;
         tally_and_finish();
      end
   end
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Strobes rise and fall on falling edges so the rising edge sees them settled
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      reg_wr_en = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge sys_clk);
      reg_wr_en = 1'b0;
   endtask : wr
   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      @(negedge sys_clk);
      reg_rd_en = 1'b1;
      reg_addr = a;
      @(negedge sys_clk);
      reg_rd_en = 1'b0;
      chk(24'(reg_rvalid), 24'h00_0001);
      chk(24'(reg_rdata), 24'(e));
   endtask : rd
   // Load one instruction through its triplet, read it back, then fetch it
   task automatic instr(input logic [7:0] pg, input int k, input logic play, input logic [23:0] v);
      logic [6:0] a;
      logic [9:0] idx;
      a = 7'(2 + 3 * k);
      idx = play ? 10'(32 * (pg - 8'h40) + k) : 10'(32 * (pg - 8'h20) + k);
      wr(7'h00, pg);
      chk(24'(page_sel), 24'(pg));
      wr(a, v[23:16]);
      wr(a + 7'h01, v[15:8]);
      wr(a + 7'h02, v[7:0]);
      rd(a, play ? v[23:16] : {4'h0, v[19:16]});
      rd(a + 7'h01, v[15:8]);
      rd(a + 7'h02, v[7:0]);
      @(negedge sys_clk);
      if (play) begin
         play_fetch_addr = idx;
      end else begin
         rec_fetch_addr = idx[8:0];
      end
      @(negedge sys_clk);
      chk(play ? play_fetch_data : 24'(rec_fetch_data), play ? v : 24'(v[19:0]));
   endtask : instr
   initial begin
      repeat (8) @(negedge sys_clk);
      rst = 1'b0;
      chk(24'(page_sel), 24'h00_0000);
      rd(7'h00, 8'h00);
      wr(7'h00, 8'hFF);
      rd(7'h00, 8'hFF);
      rd(7'h02, 8'h00);
      wr(7'h01, 8'h00);
      rd(7'h01, 8'h00);
      instr(8'h20, 0, 1'b0, 24'hA5_1234);
      instr(8'h21, 1, 1'b0, 24'h0F_EDCB);
      instr(8'h2B, 31, 1'b0, 24'hF6_789A);
      instr(8'h40, 0, 1'b1, 24'hC3_5A69);
      instr(8'h41, 5, 1'b1, 24'h3C_A596);
      instr(8'h5F, 31, 1'b1, 24'h9E_0F1D);
      wr(7'h62, 8'h00);
      rd(7'h62, 8'h00);
      rd(7'h7F, 8'h00);
      tally_and_finish();
   end
   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : tally_and_finish
endmodule : test_dsp_instruction_ram_window
